// ===== addr_input_defines.vh
`ifndef ADDR_INPUT_DEFINES_VH
`define ADDR_INPUT_DEFINES_VH

// clock rate in kHz
`define MCLK_KHZ             250000
// mode filter window in microseconds, min and max
`define MODE_FILTER_MIN_US   7680
`define MODE_FILTER_MAX_US   8192
// mode filter length in cycles: least time rounded up
`define MODE_FILTER_CYCLES   ((`MODE_FILTER_MIN_US * (`MCLK_KHZ / 1000)) + 1)
// operating mode codes
`define OPMODE_SLAVE         2'h0
`define OPMODE_MASTER        2'h1
`define OPMODE_REPEATER      2'h2
`define OPMODE_MONITOR       2'h3
// input mode codes
`define INMODE_PHOTO         1'b0
`define INMODE_LOGIC         1'b1
// register offsets
`define REG_CTRL             12'h000
`define REG_STATUS           12'h004
// control field positions
`define CTRL_OPMODE_LSB      0
`define CTRL_INIT_DONE_BIT   2
`define CTRL_ACTIVATE_BIT    3
`define CTRL_RESET_VAL       32'h00000000

`endif

// ===== addressing_input_mode_select.v
`include "addr_input_defines.vh"

module addressing_input_mode_select #(
  parameter FILTER_CYCLES = `MODE_FILTER_CYCLES
) (
  // clock, reset, enable
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire        clk_en_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // pins
  input  wire        addressing_input_i,
  input  wire        polarity_select_a_i,
  input  wire        polarity_select_b_i,
  input  wire        sequence_valid_i,
  // mode outputs
  output reg         logic_input_mode_o,
  output reg         stream_active_high_o,
  output reg         channel_locked_o,
  output reg         power_fail_pullup_en_o
);

  // how the block works
  // the pin level is compared with its value one cycle earlier;
  // while it holds still and differs from the current input mode,
  // a counter runs, and when it reaches the filter length the
  // mode follows the pin; any change of level clears the counter,
  // so only an unbroken interval counts
  // the end of the init phase takes one sample of the pin as the
  // starting mode, with no filtering at all; software decides when
  // that moment is by setting the init done bit
  // once an activation sequence is accepted the lock is set and
  // the mode stays where it was until the next reset or until slave mode is left; the lock
  // has no software clear on purpose, so a stray write cannot
  // release it
  // outside slave mode the pin is always a logic input and the
  // filter rests; the power-fail pull-up is switched off there
  // the polarity output follows the select pins in every mode;
  // only master mode gives it a meaning
  // the register bus answers in the access cycle with no wait
  // states; an unmapped offset ends with an error response
  // a low clock enable freezes every register, bus answer
  // included, so a master must not run transfers while it is low

  // last count of the level filter; 32 bits so the compare drops no bits
  localparam [31:0] FILT_LAST = FILTER_CYCLES - 1;

  // control and mode state
  reg  [31:0] ctrl_reg;           // software control word
  reg         init_done_q_reg;    // init done, one cycle late
  reg         photo_mode_n_reg;   // current input mode (1 = logic)
  reg         locked_reg;         // channel lock, cleared only by reset
  reg  [23:0] filt_cnt_reg;       // level duration counter
  reg         filt_lvl_reg;       // input level one cycle ago
  // next-state values from the combinational processes
  reg         inmode_next;        // input mode after this cycle
  reg  [23:0] filt_cnt_next;      // duration count after this cycle
  reg  [31:0] prdata_next;        // read word for the access cycle

  // register decode: exact byte address match
  function reg_hit;
    input [11:0] addr;
    input [11:0] offs;
    begin
      reg_hit = (addr == offs);
    end
  endfunction

  // filter count reaching its last cycle
  function filt_done;
    input [23:0] cnt;
    begin
      filt_done = ({8'h00, cnt} >= FILT_LAST);
    end
  endfunction

  // decoded control fields
  wire [1:0]  opmode     = ctrl_reg[`CTRL_OPMODE_LSB +: 2];
  wire        init_done  = ctrl_reg[`CTRL_INIT_DONE_BIT];
  wire        slave_mode = (opmode == `OPMODE_SLAVE);
  // end of init seen as a rising edge of the flag
  wire        init_edge  = init_done & ~init_done_q_reg;

  // apb decode; setup has psel high and penable low
  wire        apb_setup  = psel_i & ~penable_i;
  wire        apb_acc    = psel_i & penable_i;
  wire        apb_wr     = apb_acc & pwrite_i;
  wire        hit_ctrl   = reg_hit(paddr_i, `REG_CTRL);
  wire        hit_stat   = reg_hit(paddr_i, `REG_STATUS);
  wire        hit_any    = hit_ctrl | hit_stat;
  // writes land only in the access cycle, when pready is high
  wire        ctrl_wr    = apb_wr & hit_ctrl;

  // activation by pin strobe or software strobe
  wire        act_req    = sequence_valid_i
                         | (ctrl_wr & pwdata_i[`CTRL_ACTIVATE_BIT]);
  // lock is only taken in slave mode once init is over
  wire        lock_set   = slave_mode & init_done & act_req;

  // status word: sampled level, lock, polarity, input mode
  wire [31:0] status_word = {28'h0000000, filt_lvl_reg, locked_reg,
                             stream_active_high_o, photo_mode_n_reg};

  // mode and filter next state; priority order matters:
  // non-slave forcing beats the lock, the lock beats the filter
  always @* begin
    inmode_next   = photo_mode_n_reg;
    filt_cnt_next = filt_cnt_reg;
    if (!slave_mode) begin
      // master, repeater, monitor: logic level only
      inmode_next   = `INMODE_LOGIC;
      filt_cnt_next = 24'h000000;
    end else if (locked_reg) begin
      // frozen until reset or until slave mode is left
      filt_cnt_next = 24'h000000;
    end else if (init_edge) begin
      // one sample of the pin picks the starting mode
      inmode_next   = addressing_input_i;
      filt_cnt_next = 24'h000000;
    end else if (!init_done) begin
      // still initialising: keep the counter idle
      filt_cnt_next = 24'h000000;
    end else if (addressing_input_i != filt_lvl_reg) begin
      // level broken: the interval starts over
      filt_cnt_next = 24'h000000;
    end else if (addressing_input_i == photo_mode_n_reg) begin
      // already in the mode this level asks for
      filt_cnt_next = 24'h000000;
    end else if (filt_done(filt_cnt_reg)) begin
      // level held long enough: switch while unlocked
      inmode_next   = addressing_input_i;
      filt_cnt_next = 24'h000000;
    end else begin
      // still qualifying
      filt_cnt_next = filt_cnt_reg + 24'h000001;
    end
  end

  // read mux; unmapped offsets read as zero
  always @* begin
    prdata_next = 32'h00000000;
    if (hit_ctrl) begin
      // activation strobe is write-only and reads back as zero
      prdata_next = {29'h0000000, ctrl_reg[2:0]};
    end else if (hit_stat) begin
      prdata_next = status_word;
    end
  end

  // control register; only the three stored bits are kept
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // asynchronous clear to the idle value
      ctrl_reg <= `CTRL_RESET_VAL;
    end else if (clk_en_i) begin
      // advances only with the clock enable
      if (ctrl_wr) begin
        ctrl_reg <= {29'h0000000, pwdata_i[2:0]};
      end
    end
  end

  // delayed init flag for the edge detector; resets low like the flag
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // low, so no false edge follows reset
      init_done_q_reg <= 1'b0;
    end else if (clk_en_i) begin
      // advances only with the clock enable
      init_done_q_reg <= init_done;
    end
  end

  // input mode register
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // photo-current until init picks a mode
      photo_mode_n_reg <= `INMODE_PHOTO;
    end else if (clk_en_i) begin
      // advances only with the clock enable
      photo_mode_n_reg <= inmode_next;
    end
  end

  // previous input level; the filter compares against it
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // asynchronous clear
      filt_lvl_reg <= 1'b0;
    end else if (clk_en_i) begin
      // advances only with the clock enable
      filt_lvl_reg <= addressing_input_i;
    end
  end

  // level duration counter; its width fits the default length
  // with room to spare; only a filter beyond the 24-bit count range needs a wider counter
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // asynchronous clear
      filt_cnt_reg <= 24'h000000;
    end else if (clk_en_i) begin
      // advances only with the clock enable
      filt_cnt_reg <= filt_cnt_next;
    end
  end

  // channel lock; nothing but reset clears it
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // reset deactivates the channel and frees the mode
      locked_reg <= 1'b0;
    end else if (clk_en_i) begin
      // advances only with the clock enable
      if (lock_set) begin
        locked_reg <= 1'b1;
      end
    end
  end

  // apb answer: pready in the access cycle, no wait states
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // bus idle after reset
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else if (clk_en_i) begin
      pready_o  <= apb_setup;
      // unmapped offsets are refused with an error, writes dropped
      pslverr_o <= apb_setup & ~hit_any;
      // read data captured at setup so it stands in the access cycle
      if (apb_setup) begin
        prdata_o <= prdata_next;
      end
    end
  end

  // input mode output, one cycle behind the decision
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // photo-current after reset
      logic_input_mode_o <= 1'b0;
    end else if (clk_en_i) begin
      // advances only with the clock enable
      logic_input_mode_o <= inmode_next;
    end
  end

  // bit-stream polarity from the two select pins; only master
  // mode uses it, so it is left running in every mode
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // active low stream, idle one
      stream_active_high_o <= 1'b0;
    end else if (clk_en_i) begin
      // equal pins low, unequal pins high
      stream_active_high_o <= polarity_select_a_i ^ polarity_select_b_i;
    end
  end

  // lock flag output
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // unlocked after reset
      channel_locked_o <= 1'b0;
    end else if (clk_en_i) begin
      // advances only with the clock enable
      channel_locked_o <= locked_reg;
    end
  end

  // power-fail pull-up only in slave mode; the analog
  // comparator needs an unloaded pin in the other modes
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // reset leaves the block in slave mode
      power_fail_pullup_en_o <= 1'b1;
    end else if (clk_en_i) begin
      // advances only with the clock enable
      power_fail_pullup_en_o <= slave_mode;
    end
  end

endmodule

// ===== mode_sel_properties.sv
module mode_sel_properties (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic addressing_input_i,
  input wire logic polarity_select_a_i,
  input wire logic polarity_select_b_i,
  // mode outputs
  input wire logic logic_input_mode_o,
  input wire logic stream_active_high_o,
  input wire logic channel_locked_o,
  input wire logic power_fail_pullup_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // level broken, then three cycles of room for the output lag
  sequence brk;
    $changed(addressing_input_i) ##3 1'b1;
  endsequence
  AST_POL_EQ:
  assert property ((polarity_select_a_i == polarity_select_b_i) [*2] |-> !stream_active_high_o)
    else $error("equal selects gave active high");
  AST_POL_NE:
  assert property ((polarity_select_a_i != polarity_select_b_i) [*2] |-> stream_active_high_o)
    else $error("unequal selects gave active low");
  AST_LOCK_HOLD:
  assert property (channel_locked_o |=> channel_locked_o) else $error("lock dropped");
  AST_MODE_FROZEN:
  assert property (channel_locked_o |=> $stable(logic_input_mode_o)) else $error("mode moved");
  AST_RISE_HIGH:
  assert property ($rose(logic_input_mode_o) && power_fail_pullup_en_o
    |-> $past(addressing_input_i, 1)) else $error("logic mode without high input");
  AST_FALL_LOW:
  assert property ($fell(logic_input_mode_o) |-> !$past(addressing_input_i, 1))
    else $error("photo mode without low input");
  AST_PULLUP_OFF:
  assert property (!power_fail_pullup_en_o [*2] |-> logic_input_mode_o)
    else $error("non-slave mode not logic input");
  AST_FILTER_RESTART:
  assert property (brk |-> $stable(logic_input_mode_o) [*8]) else $error("switched too soon");
endmodule
bind addressing_input_mode_select mode_sel_properties u_chk (.*);

// ===== prog_model.sv
module prog_model (
  // clock and bench commands
  input  wire logic mclk_i,
  input  wire logic lvl_i,
  input  wire logic act_i,
  // pins toward the block
  output logic      addressing_o = 1'b1,
  output logic      seq_valid_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // edges launched on the clock, so no slow ramps reach the filter
  always @(posedge mclk_i) begin
    addressing_o <= lvl_i;
    seq_valid_o  <= act_i;
  end
endmodule

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, polarity_select_a_i = 1'b0, polarity_select_b_i = 1'b0;
  logic        lvl = 1'b1, act = 1'b0, er;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000, rd;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, addressing_input_i, sequence_valid_i;
  wire         logic_input_mode_o, stream_active_high_o, channel_locked_o, power_fail_pullup_en_o;
  int          bad_count = 0, tests_run = 0;
  // short filter keeps the run brief
  addressing_input_mode_select #(.FILTER_CYCLES(20)) DUT (.clk_en_i(1'b1), .*);
  prog_model u_prog (.mclk_i(mclk_i), .lvl_i(lvl), .act_i(act),
    .addressing_o(addressing_input_i), .seq_valid_o(sequence_valid_i));
  initial forever #2 mclk_i = ~mclk_i;
  task stop_test;
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one transfer; an extra edge keeps psel from two writes in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
    @(posedge mclk_i);
    if (pready_o !== 1'b1 && n >= 40) begin
      bad_count++;
      stop_test();
    end
  endtask
  // hold the line level, then read status
  task hold(input logic v, input int c);
    lvl <= v;
    repeat (c) @(posedge mclk_i);
    apb(1'b0, 12'h004, 32'h00000000);
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    apb(1'b1, 12'h000, 32'h00000004);
    hold(1'b1, 2);
    chk(rd[0], 1'b1);
    chk(er, 1'b0);
    hold(1'b0, 12);
    hold(1'b1, 1);
    hold(1'b0, 8);
    chk(rd[0], 1'b1);
    hold(1'b1, 30);
    chk(rd[0], 1'b1);
    hold(1'b0, 30);
    chk(rd[0], 1'b0);
    hold(1'b1, 30);
    chk(rd[0], 1'b1);
    act <= 1'b1;
    @(posedge mclk_i);
    act <= 1'b0;
    hold(1'b0, 30);
    chk(rd[2], 1'b1);
    chk(channel_locked_o, 1'b1);
    chk(rd[0], 1'b1);
    apb(1'b0, 12'h010, 32'h00000000);
    chk(er, 1'b1);
    apb(1'b1, 12'h000, 32'h00000005);
    @(posedge mclk_i);
    chk(power_fail_pullup_en_o, 1'b0);
    chk(logic_input_mode_o, 1'b1);
    for (int i = 0; i < 4; i++) begin
      {polarity_select_a_i, polarity_select_b_i} <= i[1:0];
      repeat (3) @(posedge mclk_i);
      chk(stream_active_high_o, i[1] ^ i[0]);
    end
    rst_n_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk(channel_locked_o, 1'b0);
    chk(power_fail_pullup_en_o, 1'b1);
    apb(1'b1, 12'h000, 32'h00000004);
    hold(1'b0, 2);
    chk(rd[0], 1'b0);
    hold(1'b1, 30);
    chk(rd[0], 1'b1);
    chk(logic_input_mode_o, 1'b1);
    stop_test();
  end
endmodule
